// ### pkg/fcc_defines.svh
// register offsets, field positions, reset values and frame lengths
// included by the package and by the calibrator and core design files of this block
`ifndef FCC_DEFINES_SVH
`define FCC_DEFINES_SVH

`define FCC_ADDR_NOP          7'h00
`define FCC_ADDR_SOFT_RESET   7'h01
`define FCC_ADDR_RESET_CFG    7'h02
`define FCC_ADDR_CHAN_SEL     7'h03
`define FCC_ADDR_CHAN_CFG     7'h04
`define FCC_ADDR_CHAN_CODE    7'h05
`define FCC_ADDR_CONV_SEL     7'h06
`define FCC_ADDR_CONV_CFG     7'h07
`define FCC_ADDR_CAL_EN       7'h08
`define FCC_ADDR_GAIN_TRIM    7'h09
`define FCC_ADDR_OFFSET_TRIM  7'h0a
`define FCC_ADDR_STATUS       7'h0b
`define FCC_ADDR_STATUS_MASK  7'h0c
`define FCC_ADDR_FAULT_ACTION 7'h0d
`define FCC_ADDR_FAULT_CODE   7'h0e
`define FCC_ADDR_WDOG_RESTART 7'h10
`define FCC_ADDR_PART_ID      7'h11

`define FCC_SOFT_RESET_BIT    0
`define FCC_CHECK_EN_BIT      3
`define FCC_SOUT_OFF_BIT      4
`define FCC_CHAN_SEL_LSB      5
`define FCC_CLEAR_LEVEL_LSB   9
`define FCC_CAL_EN_BIT        0
`define FCC_FRAME_ERR_BIT     5
`define FCC_FRAME_ERR_MASK_BIT 5

`define FCC_RESET_ZERO        16'h0000
`define FCC_GAIN_RESET        16'h8000
`define FCC_STATUS_RESET      16'h1000
`define FCC_MIDSCALE          16'h8000
`define FCC_GAIN_BIAS         17'h0_8000

`define FCC_CRC_POLY          8'h07
`define FCC_FRAME_LEN_PLAIN   6'h18
`define FCC_FRAME_LEN_CHECK   6'h20

`endif

// ### pkg/fcc_pkg.sv
// types and the frame checksum function shared by the block's files
// assumes the defines header is on the include path
`include "fcc_defines.svh"

package fcc_pkg;

    typedef struct packed {
        logic        rd;
        logic [6:0]  addr;
        logic [15:0] data;
    } cmd_s;

    typedef logic [3:0][15:0] chan_codes_t;

    // msb-first division, checker starts at zero
    function automatic logic [7:0] crc8_calc(input logic [31:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `FCC_CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8_calc

endpackage : fcc_pkg

// ### design/pin_sync.sv
// two-flop synchroniser, one pair per bit
// inputs are asynchronous to clock_in; first stage feeds only the second
`timescale 1ns/100ps

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock_in) begin
            if (!rst_n_in) begin
                meta_r[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else if (ce_in) begin
                meta_r[i]   <= async_in[i];
                sync_out[i] <= meta_r[i];
            end
        end
    end

endmodule : pin_sync

// ### design/code_calibrator.sv
// gain and offset correction of one 16-bit channel code
// result registered, one cycle after the inputs
`timescale 1ns/100ps
`include "fcc_defines.svh"

module code_calibrator (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic [15:0] code_in,
    input  wire logic [15:0] gain_in,
    input  wire logic [15:0] offset_in,
    output logic      [15:0] code_out
);
    logic [16:0] gain_term;
    logic [32:0] product;
    logic [17:0] sum;
    logic [15:0] clamped;

    assign gain_term = {1'b0, gain_in} + `FCC_GAIN_BIAS;
    assign product   = {17'h0_0000, code_in} * {16'h0000, gain_term};
    // product is never negative, so dropping low bits is the floor
    assign sum = {1'b0, product[32:16]} + {{2{offset_in[15]}}, offset_in};
    assign clamped = sum[17] ? 16'h0000 :
                     sum[16] ? 16'hffff : sum[15:0];

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            code_out <= 16'h0000;
        end else if (ce_in) begin
            code_out <= clamped;
        end
    end

endmodule : code_calibrator

// ### design/frame_check_clear_calibration.sv
// serial command core: frame capture, checksum, register map,
// clear handling and per-channel calibration of four output codes
// the serial, strobe and clear pins are asynchronous and pass two flops before use; the serial
// clock must stay well below a quarter of clock_in
`timescale 1ns/100ps
`include "fcc_defines.svh"

module frame_check_clear_calibration #(
    parameter int         CHANNELS = 4,
    parameter logic [2:0] PART_ID  = 3'h5 // arbitrary value
) (
    input  wire logic                clock_in,
    input  wire logic                rst_n_in,
    input  wire logic                ce_in,
    input  wire logic                sclk_in,
    input  wire logic                frame_select_n_in,
    input  wire logic                sdin_in,
    input  wire logic                load_outputs_strobe_n_in,
    input  wire logic                output_clear_pin_in,
    output logic                     serial_out_pin_out,
    output logic                     serial_out_pin_oe_out,
    output logic                     fault_alert_n_out,
    output fcc_pkg::chan_codes_t     channel_code_out
);
    import fcc_pkg::*;

    // high-idle pins go in inverted: no false edge after reset
    logic [4:0] pins_s;
    logic       sclk_d_r;
    logic       fs_n_d_r;
    logic       strb_n_d_r;

    pin_sync #(.WIDTH(5)) u_pin_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .async_in ({output_clear_pin_in, ~load_outputs_strobe_n_in,
                    sdin_in, ~frame_select_n_in, ~sclk_in}),
        .sync_out (pins_s)
    );

    wire sclk_s     = ~pins_s[0];
    wire fs_n_s     = ~pins_s[1];
    wire sdin_s     = pins_s[2];
    wire strb_n_s   = ~pins_s[3];
    wire clear_s    = pins_s[4];
    wire sclk_fall  = sclk_d_r & ~sclk_s;
    wire sclk_rise  = ~sclk_d_r & sclk_s;
    wire frame_on   = ~fs_n_s;
    wire frame_beg  = fs_n_d_r & ~fs_n_s;
    wire frame_end  = ~fs_n_d_r & fs_n_s;
    wire strb_fall  = strb_n_d_r & ~strb_n_s;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sclk_d_r   <= 1'b1;
            fs_n_d_r   <= 1'b1;
            strb_n_d_r <= 1'b1;
        end else if (ce_in) begin
            sclk_d_r   <= sclk_s;
            fs_n_d_r   <= fs_n_s;
            strb_n_d_r <= strb_n_s;
        end
    end

    // soft reset pulse and the combined register reset
    logic soft_rst_r;
    wire  regs_rst = !rst_n_in || soft_rst_r;

    // receive shift register
    logic [31:0] rx_sh_r;
    logic [5:0]  rx_cnt_r;
    logic [31:0] frame_r;
    logic [5:0]  frame_cnt_r;
    logic        commit_pend_r;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rx_sh_r  <= 32'h0000_0000;
            rx_cnt_r <= 6'h00;
        end else if (ce_in) begin
            if (frame_beg) begin
                rx_cnt_r <= 6'h00;
            end else if (frame_on && sclk_fall) begin
                rx_sh_r <= {rx_sh_r[30:0], sdin_s};
                if (rx_cnt_r != `FCC_FRAME_LEN_CHECK) begin
                    rx_cnt_r <= rx_cnt_r + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            frame_r       <= 32'h0000_0000;
            frame_cnt_r   <= 6'h00;
            commit_pend_r <= 1'b0;
        end else if (ce_in) begin
            commit_pend_r <= frame_end;
            if (frame_end) begin
                frame_r     <= rx_sh_r;
                frame_cnt_r <= rx_cnt_r;
            end
        end
    end

    // global registers
    logic [15:0] reset_cfg_r;
    logic [15:0] chan_sel_r;
    logic [15:0] conv_sel_r;
    logic [15:0] status_r;
    logic [15:0] status_mask_r;
    logic [15:0] fault_action_r;

    wire check_on = chan_sel_r[`FCC_CHECK_EN_BIT];

    // frame decode; checked frames carry command in the top 24 bits
    cmd_s cmd;
    assign cmd = check_on ? frame_r[31:8] : frame_r[23:0];

    wire len_ok = check_on ? (frame_cnt_r >= `FCC_FRAME_LEN_CHECK)
                           : (frame_cnt_r >= `FCC_FRAME_LEN_PLAIN);
    wire crc_good  = crc8_calc(frame_r) == 8'h00;
    wire frame_ok  = commit_pend_r && len_ok;
    wire crc_fail  = frame_ok && check_on && !crc_good;
    wire cmd_take  = frame_ok && (!check_on || crc_good);
    wire wr_take   = cmd_take && !cmd.rd;
    wire rd_take   = cmd_take && cmd.rd;

    // write decode, reserved and unknown addresses do nothing
    wire wr_soft   = wr_take && cmd.addr == `FCC_ADDR_SOFT_RESET;
    wire wr_rcfg   = wr_take && cmd.addr == `FCC_ADDR_RESET_CFG;
    wire wr_csel   = wr_take && cmd.addr == `FCC_ADDR_CHAN_SEL;
    wire wr_ccfg   = wr_take && cmd.addr == `FCC_ADDR_CHAN_CFG;
    wire wr_code   = wr_take && cmd.addr == `FCC_ADDR_CHAN_CODE;
    wire wr_vsel   = wr_take && cmd.addr == `FCC_ADDR_CONV_SEL;
    wire wr_vcfg   = wr_take && cmd.addr == `FCC_ADDR_CONV_CFG;
    wire wr_calen  = wr_take && cmd.addr == `FCC_ADDR_CAL_EN;
    wire wr_gain   = wr_take && cmd.addr == `FCC_ADDR_GAIN_TRIM;
    wire wr_off    = wr_take && cmd.addr == `FCC_ADDR_OFFSET_TRIM;
    wire wr_mask   = wr_take && cmd.addr == `FCC_ADDR_STATUS_MASK;
    wire wr_action = wr_take && cmd.addr == `FCC_ADDR_FAULT_ACTION;
    wire wr_fcode  = wr_take && cmd.addr == `FCC_ADDR_FAULT_CODE;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            soft_rst_r <= 1'b0;
        end else if (ce_in) begin
            soft_rst_r <= wr_soft && cmd.data[`FCC_SOFT_RESET_BIT];
        end
    end

    always_ff @(posedge clock_in) begin
        if (regs_rst) begin
            reset_cfg_r    <= `FCC_RESET_ZERO;
            chan_sel_r     <= `FCC_RESET_ZERO;
            conv_sel_r     <= `FCC_RESET_ZERO;
            status_mask_r  <= `FCC_RESET_ZERO;
            fault_action_r <= `FCC_RESET_ZERO;
        end else if (ce_in) begin
            if (wr_rcfg) reset_cfg_r <= cmd.data;
            if (wr_csel) chan_sel_r <= cmd.data;
            if (wr_vsel) conv_sel_r <= cmd.data;
            if (wr_mask) status_mask_r <= cmd.data;
            if (wr_action) fault_action_r <= cmd.data;
        end
    end

    // frame error flag: set wins over the disable clear
    logic frame_error_flag_nxt;
    assign frame_error_flag_nxt =
        crc_fail || (check_on && status_r[`FCC_FRAME_ERR_BIT]);

    always_ff @(posedge clock_in) begin
        if (regs_rst) begin
            status_r <= `FCC_STATUS_RESET;
        end else if (ce_in) begin
            status_r[`FCC_FRAME_ERR_BIT] <=
                frame_error_flag_nxt;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            fault_alert_n_out <= 1'b1;
        end else if (ce_in) begin
            fault_alert_n_out <= !(status_r[`FCC_FRAME_ERR_BIT] &&
                !status_mask_r[`FCC_FRAME_ERR_MASK_BIT]);
        end
    end

    // per-channel registers, calibration and output stage
    logic [15:0] ch_cfg_r   [CHANNELS];
    logic [15:0] ch_code_r  [CHANNELS];
    logic [15:0] ch_latch_r [CHANNELS];
    logic [15:0] ch_gain_r  [CHANNELS];
    logic [15:0] ch_off_r   [CHANNELS];
    logic [15:0] ch_fcode_r [CHANNELS];
    logic [15:0] ch_vcfg_r  [CHANNELS];
    logic [15:0] ch_cal_out [CHANNELS];
    logic        ch_calen_r [CHANNELS];
    logic        ch_pend_r  [CHANNELS];
    logic        ch_clr_r   [CHANNELS];

    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
        wire chan_on = chan_sel_r[`FCC_CHAN_SEL_LSB + i];
        wire conv_on = conv_sel_r[i];
        wire clr_lvl = chan_sel_r[`FCC_CLEAR_LEVEL_LSB + i];
        // latch loads at once with the strobe low, else on its fall
        wire load_now = (wr_code && chan_on && !strb_n_s) ||
                        (ch_pend_r[i] && strb_fall && !clear_s);
        wire [15:0] clr_code = clr_lvl ? `FCC_MIDSCALE : 16'h0000;

        // clear pin never touches these
        always_ff @(posedge clock_in) begin
            if (regs_rst) begin
                ch_cfg_r[i]   <= `FCC_RESET_ZERO;
                ch_code_r[i]  <= `FCC_RESET_ZERO;
                ch_gain_r[i]  <= `FCC_GAIN_RESET;
                ch_off_r[i]   <= `FCC_RESET_ZERO;
                ch_fcode_r[i] <= `FCC_RESET_ZERO;
                ch_vcfg_r[i]  <= `FCC_RESET_ZERO;
                ch_calen_r[i] <= 1'b0;
            end else if (ce_in) begin
                if (wr_ccfg && chan_on) ch_cfg_r[i] <= cmd.data;
                if (wr_code && chan_on) ch_code_r[i] <= cmd.data;
                if (wr_gain && chan_on) ch_gain_r[i] <= cmd.data;
                if (wr_off && chan_on) ch_off_r[i] <= cmd.data;
                if (wr_fcode && chan_on) ch_fcode_r[i] <= cmd.data;
                if (wr_vcfg && conv_on) ch_vcfg_r[i] <= cmd.data;
                if (wr_calen && chan_on) begin
                    ch_calen_r[i] <= cmd.data[`FCC_CAL_EN_BIT];
                end
            end
        end

        always_ff @(posedge clock_in) begin
            if (regs_rst) begin
                ch_latch_r[i] <= `FCC_RESET_ZERO;
                ch_pend_r[i]  <= 1'b0;
                ch_clr_r[i]   <= 1'b0;
            end else if (ce_in) begin
                if (wr_code && chan_on) begin
                    ch_pend_r[i] <= strb_n_s;
                end else if (load_now) begin
                    ch_pend_r[i] <= 1'b0;
                end
                if (load_now) begin
                    ch_latch_r[i] <= wr_code && chan_on ? cmd.data
                                                        : ch_code_r[i];
                end
                if (clear_s) begin
                    ch_clr_r[i] <= 1'b1;
                end else if (load_now) begin
                    ch_clr_r[i] <= 1'b0;
                end
            end
        end

        code_calibrator u_cal (
            .clock_in  (clock_in),
            .rst_n_in  (rst_n_in),
            .ce_in     (ce_in),
            .code_in   (ch_latch_r[i]),
            .gain_in   (ch_gain_r[i]),
            .offset_in (ch_off_r[i]),
            .code_out  (ch_cal_out[i])
        );

        // pin level bypasses the sticky flag so clearing is immediate
        always_ff @(posedge clock_in) begin
            if (!rst_n_in) begin
                channel_code_out[i] <= 16'h0000;
            end else if (ce_in) begin
                if (clear_s || ch_clr_r[i]) begin
                    channel_code_out[i] <= clr_code;
                end else if (ch_calen_r[i]) begin
                    channel_code_out[i] <= ch_cal_out[i];
                end else begin
                    channel_code_out[i] <= ch_latch_r[i];
                end
            end
        end
    end

    // readback picks the lowest selected channel and converter
    logic [1:0] rd_ch;
    logic [1:0] rd_cv;

    always_comb begin
        rd_ch = 2'd0;
        rd_cv = 2'd0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (chan_sel_r[`FCC_CHAN_SEL_LSB + i]) rd_ch = 2'(i);
            if (conv_sel_r[i]) rd_cv = 2'(i);
        end
    end

    logic [15:0] rd_data;
    always_comb begin
        if (cmd.addr == `FCC_ADDR_RESET_CFG) rd_data = reset_cfg_r;
        else if (cmd.addr == `FCC_ADDR_CHAN_SEL) rd_data = chan_sel_r;
        else if (cmd.addr == `FCC_ADDR_CHAN_CFG) rd_data = ch_cfg_r[rd_ch];
        else if (cmd.addr == `FCC_ADDR_CHAN_CODE) rd_data = ch_code_r[rd_ch];
        else if (cmd.addr == `FCC_ADDR_CONV_SEL) rd_data = conv_sel_r;
        else if (cmd.addr == `FCC_ADDR_CONV_CFG) rd_data = ch_vcfg_r[rd_cv];
        else if (cmd.addr == `FCC_ADDR_CAL_EN)
            rd_data = {15'h0000, ch_calen_r[rd_ch]};
        else if (cmd.addr == `FCC_ADDR_GAIN_TRIM) rd_data = ch_gain_r[rd_ch];
        else if (cmd.addr == `FCC_ADDR_OFFSET_TRIM) rd_data = ch_off_r[rd_ch];
        else if (cmd.addr == `FCC_ADDR_STATUS) rd_data = status_r;
        else if (cmd.addr == `FCC_ADDR_STATUS_MASK) rd_data = status_mask_r;
        else if (cmd.addr == `FCC_ADDR_FAULT_ACTION) rd_data = fault_action_r;
        else if (cmd.addr == `FCC_ADDR_FAULT_CODE) rd_data = ch_fcode_r[rd_ch];
        else if (cmd.addr == `FCC_ADDR_PART_ID) rd_data = {13'h0000, PART_ID};
        else rd_data = 16'h0000;
    end

    // readback word: address byte, data, then checksum when checking
    wire [23:0] rd_word = {cmd.rd, cmd.addr, rd_data};
    wire [7:0]  rd_crc  = check_on ? crc8_calc({8'h00, rd_word})
                                   : 8'h00;
    logic [31:0] tx_sh_r;

    // shifts on the serial clock rise so the bit is stable at the fall
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tx_sh_r <= 32'h0000_0000;
        end else if (ce_in) begin
            if (rd_take) begin
                tx_sh_r <= {rd_word, rd_crc};
            end else if (frame_on && sclk_rise) begin
                tx_sh_r <= {tx_sh_r[30:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            serial_out_pin_out    <= 1'b0;
            serial_out_pin_oe_out <= 1'b0;
        end else if (ce_in) begin
            serial_out_pin_out    <= tx_sh_r[31];
            serial_out_pin_oe_out <= frame_on &&
                !chan_sel_r[`FCC_SOUT_OFF_BIT];
        end
    end

endmodule : frame_check_clear_calibration

// ### sim/fcc_checker_assertions.sv
// pin-level checker for the serial command core
// bound into every core instance; assumes ce_in drops only while idle
`timescale 1ns/100ps

module fcc_checker (
    input wire logic                 clock_in,
    input wire logic                 rst_n_in,
    input wire logic                 frame_select_n_in,
    input wire logic                 load_outputs_strobe_n_in,
    input wire logic                 output_clear_pin_in,
    input wire logic                 serial_out_pin_oe_out,
    input wire logic                 fault_alert_n_out,
    input wire fcc_pkg::chan_codes_t channel_code_out
);
    import fcc_pkg::*;
    logic cleared_w;

    function automatic logic is_clr(input logic [15:0] c);
        return c == 16'h0000 || c == 16'h8000;
    endfunction : is_clr

    assign cleared_w = is_clr(channel_code_out[0])
        && is_clr(channel_code_out[1]) && is_clr(channel_code_out[2])
        && is_clr(channel_code_out[3]);

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    AST_RESET_OUTS: assert property (
        $rose(rst_n_in) |-> fault_alert_n_out && !serial_out_pin_oe_out
            && channel_code_out == '0) else $error("not idle after reset");
    AST_OE_IDLE: assert property (
        frame_select_n_in [*4] |-> !serial_out_pin_oe_out
    ) else $error("serial out driven outside a frame");
    AST_CLEAR_FORCE: assert property (
        output_clear_pin_in [*5] |-> cleared_w
    ) else $error("clear held but code not cleared");
    AST_CLEAR_FAST: assert property (
        $rose(output_clear_pin_in) |-> ##[1:4] cleared_w
    ) else $error("clear applied late");
    AST_CLEAR_STABLE: assert property (
        output_clear_pin_in [*6] |-> $stable(channel_code_out)
    ) else $error("codes moved while clear held");
    // release with no strobe and no frame must not leave clear value
    AST_CLEAR_HOLD: assert property (
        (output_clear_pin_in && load_outputs_strobe_n_in) [*4] ##1
        (!output_clear_pin_in && load_outputs_strobe_n_in
            && frame_select_n_in) [*8] |-> $stable(channel_code_out)
    ) else $error("codes left clear value without new data");
    AST_ALERT_QUIET: assert property (
        !frame_select_n_in [*3] |=> $stable(fault_alert_n_out)
    ) else $error("alert moved mid-frame");
    AST_CODE_QUIET: assert property (
        (!frame_select_n_in && !output_clear_pin_in) [*8]
            |-> $stable(channel_code_out)
    ) else $error("codes moved mid-frame");
endmodule : fcc_checker

bind frame_check_clear_calibration fcc_checker checker_i (.clock_in,
    .rst_n_in, .frame_select_n_in, .load_outputs_strobe_n_in,
    .output_clear_pin_in, .serial_out_pin_oe_out, .fault_alert_n_out,
    .channel_code_out);

// ### sim/spi_host_model.sv
// host serial controller model: sends frames, collects readback
// steps on clock_in falls; 8 clocks per serial bit (64 ns)
`timescale 1ns/100ps

module spi_host_model (
    input  wire logic clock_in,
    input  wire logic serial_in,
    input  wire logic serial_oe_in,
    output logic      sclk_out,
    output logic      frame_select_n_out,
    output logic      sdin_out
);
    logic line_r = 1'b0;

    initial begin
        sclk_out = 1'b1;
        frame_select_n_out = 1'b1;
        sdin_out = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clock_in);
    endtask : hold

    // exact bit count per frame; clock parks high between frames
    task automatic xfer(input logic [31:0] tx, input int n,
                        output logic [31:0] rx);
        rx = '0;
        frame_select_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdin_out = tx[i];
            hold(4);
            sclk_out = 1'b0;
            hold(4);
            // undriven line shows the inverse of its last level
            line_r = serial_oe_in ? serial_in : ~line_r;
            rx[i] = line_r;
            sclk_out = 1'b1;
        end
        hold(4);
        frame_select_n_out = 1'b1;
        sdin_out = ~sdin_out;
        hold(12);
    endtask : xfer
endmodule : spi_host_model

// ### sim/frame_check_clear_calibration_tb.sv
// bench for the serial command core: registers, trims, clear pin and
// frame checking via the host model; checker comes in by bind
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value at %0t: %h, expected %h", \
    $time, g, e); end end

module frame_check_clear_calibration_tb;
    import fcc_pkg::*;
    localparam logic [2:0] ID = 3'h5; // arbitrary value
    logic        clock_in, rst_n_in, strobe_n, clear, chk_on, ce;
    logic        sclk, fsel_n, sdin, so, so_oe, alert_n;
    logic [15:0] cd, gn, of;
    logic [31:0] rx, res, want, bad, q[$];
    chan_codes_t codes;
    int          miscompares = 0, checked = 0, cycles = 0, seed;
    event        res_ev;

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    frame_check_clear_calibration #(.PART_ID(ID)) dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .sclk_in(sclk), .frame_select_n_in(fsel_n), .sdin_in(sdin),
        .load_outputs_strobe_n_in(strobe_n),
        .output_clear_pin_in(clear), .serial_out_pin_out(so),
        .serial_out_pin_oe_out(so_oe), .fault_alert_n_out(alert_n),
        .channel_code_out(codes));
    spi_host_model host (.clock_in(clock_in), .serial_in(so),
        .serial_oe_in(so_oe), .sclk_out(sclk),
        .frame_select_n_out(fsel_n), .sdin_out(sdin));

    // plain long division, remainder of the 32-bit word
    function automatic logic [7:0] crc_of(input logic [31:0] d);
        logic [8:0] r;
        r = '0;
        for (int i = 31; i >= 0; i--) begin
            r = {r[7:0], d[i]};
            if (r[8]) r = r ^ 9'h107;
        end
        return r[7:0];
    endfunction : crc_of

    function automatic logic [15:0] cal(input logic [15:0] c, g, o);
        longint v;
        v = (longint'(c) * (longint'(g) + 32768)) >>> 16;
        v = v + longint'($signed(o));
        return v < 0 ? 16'h0000 : v > 65535 ? 16'hffff : v[15:0];
    endfunction : cal

    task automatic report_and_stop();
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic post(input logic [31:0] v, input logic [31:0] e);
        q.push_back(e);
        res = v;
        ->res_ev;
        @(negedge clock_in);
    endtask : post

    task automatic frame(input logic [23:0] cmd);
        if (chk_on) host.xfer({cmd, crc_of({cmd, 8'h00})}, 32, rx);
        else host.xfer({8'h00, cmd}, 24, rx);
    endtask : frame

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        frame({1'b0, a, d});
    endtask : wr

    // read, then a no-op frame shifts the answer out
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        frame({1'b1, a, 16'h0000});
        frame(24'h00_0000);
        post(chk_on ? rx[23:8] : rx[15:0], e);
        if (chk_on) post(crc_of(rx), 32'h0000_0000);
    endtask : rd

    always @(res_ev) begin
        want = q.pop_front();
        `CHK(res, want)
    end

    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        seed = 61714;
        rst_n_in = 1'b0;
        strobe_n = 1'b0;
        clear = 1'b0;
        chk_on = 1'b0;
        ce = 1'b1;
        host.hold(6);
        rst_n_in = 1'b1;
        host.hold(4);
        host.xfer({8'ha5, 1'b0, 7'h03, 16'h0060}, 32, rx);
        rd(7'h03, 16'h0060);
        rd(7'h09, 16'h8000);
        rd(7'h0b, 16'h1000);
        wr(7'h11, 16'h0000);
        wr(7'h00, 16'hffff);
        rd(7'h11, {13'h0000, ID});
        rd(7'h03, 16'h0060);
        for (int i = 0; i < 5; i++) begin
            cd = 16'($random(seed));
            gn = 16'($random(seed));
            of = 16'($random(seed));
            if (i == 0) {cd, gn, of} = {16'h0100, 16'h0000, 16'h8000};
            if (i == 1) {cd, gn, of} = {16'hffff, 16'hffff, 16'h7fff};
            if (i > 0) wr(7'h08, 16'h0000);
            wr(7'h09, gn);
            wr(7'h0a, of);
            wr(7'h05, cd);
            post(codes[0], cd);
            wr(7'h08, 16'h0001);
            post(codes[0], cal(cd, gn, of));
            post(codes[1], cal(cd, gn, of));
            rd(7'h0a, of);
        end
        wr(7'h08, 16'h0000);
        wr(7'h03, 16'h0260);
        wr(7'h05, 16'h1234);
        strobe_n = 1'b1;
        wr(7'h05, 16'h4321);
        clear = 1'b1;
        host.hold(8);
        post(codes[0], 16'h8000);
        post(codes[1], 16'h0000);
        strobe_n = 1'b0;
        host.hold(8);
        strobe_n = 1'b1;
        host.hold(8);
        clear = 1'b0;
        host.hold(16);
        post(codes[0], 16'h8000);
        rd(7'h05, 16'h4321);
        rd(7'h0a, of);
        // frozen core must not see the strobe fall until enabled again
        ce = 1'b0;
        strobe_n = 1'b0;
        host.hold(8);
        post(codes[1], 16'h0000);
        ce = 1'b1;
        host.hold(8);
        post(codes[1], 16'h4321);
        wr(7'h03, 16'h0068);
        chk_on = 1'b1;
        wr(7'h05, 16'h0abc);
        post(codes[0], 16'h0abc);
        bad = {1'b0, 7'h05, 16'h0def, 8'h00};
        bad[7:0] = crc_of(bad) ^ 8'h01;
        host.xfer(bad, 32, rx);
        post(codes[0], 16'h0abc);
        post({31'h0000_0000, alert_n}, 32'h0000_0000);
        rd(7'h0b, 16'h1020);
        wr(7'h03, 16'h0060);
        chk_on = 1'b0;
        rd(7'h0b, 16'h1000);
        post({31'h0000_0000, alert_n}, 32'h0000_0001);
        wr(7'h01, 16'h0001);
        wr(7'h03, 16'h0020);
        rd(7'h09, 16'h8000);
        report_and_stop();
    end
endmodule : frame_check_clear_calibration_tb
